// [pkg/oas_pkg.sv]
// Constants and types shared by the operand addressing and status flag block
package oas_pkg;
  // Status word bit positions; the leftmost (bit 15) is flag 0
  localparam int FLAG_HI = 15;
  localparam int FLAG_LO = 9;
  localparam int MASK_HI = 3;
  localparam int MASK_LO = 0;
  localparam logic [15:0] STATUS_USED = 16'hfe0f;
  localparam logic [15:0] STATUS_RST = 16'h0000;

  // Operand lane masks; a byte lives in the left byte
  localparam logic [15:0] BYTE_MASK = 16'hff00;
  localparam logic [15:0] WORD_MASK = 16'hffff;
  localparam int BYTE_HI = 15;
  localparam int BYTE_LO = 8;
  localparam logic [16:0] ONE_WORD = 17'h00001;
  localparam logic [16:0] ONE_BYTE = 17'h00100;
  localparam logic [15:0] MOST_NEG = 16'h8000;
  localparam logic [15:0] ZERO16 = 16'h0000;

  // Auto-increment steps
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;

  // Serial bit base field inside workspace register 12
  localparam int BASE_HI = 14 - 2;
  localparam int BASE_LO = 1;
  localparam logic [3:0] REG_NONE = 4'h0;
  localparam logic [3:0] SER_MIN = 4'h1;
  localparam logic [3:0] SER_MAX = 4'h8;

  // Register port offsets
  localparam logic [3:0] ADR_STATUS = 4'h0;
  localparam logic [3:0] ADR_RESULT = 4'h1;
  localparam logic [3:0] ADR_EADDR = 4'h2;
  localparam logic [3:0] ADR_BITADR = 4'h3;
  localparam logic [3:0] ADR_PCTGT = 4'h4;

  typedef enum logic [1:0] {
    MODE_REG = 2'b00,
    MODE_IND = 2'b01,
    MODE_IDX = 2'b10,
    MODE_AUTO = 2'b11
  } oas_mode_e;

  typedef enum logic [4:0] {
    OP_NONE = 5'b00000, OP_ADD = 5'b00001, OP_SUB = 5'b00010,
    OP_CMP = 5'b00011, OP_CMPI = 5'b00100, OP_LOGIC = 5'b00101,
    OP_MOVE = 5'b00110, OP_COC = 5'b00111, OP_CZC = 5'b01000,
    OP_INC = 5'b01001, OP_DEC = 5'b01010, OP_NEG = 5'b01011,
    OP_ABS = 5'b01100, OP_SHL = 5'b01101, OP_SHR = 5'b01110,
    OP_DIV = 5'b01111, OP_TB = 5'b10000, OP_SERIAL = 5'b10001,
    OP_XOP = 5'b10010, OP_MASK_IMMEDIATE_LOAD = 5'b10011, OP_CONTEXT_RETURN_OP = 5'b10100
  } oas_op_e;
endpackage : oas_pkg

// [rtl/oas_core.sv]
// Operand address generation and status word flag logic
`timescale 1ns/1ps
module oas_core (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Operand address request
  input wire logic addrStb,
  input wire logic [1:0] modeSel,
  input wire logic immSel,
  input wire logic [3:0] regNum,
  input wire logic byteOp,
  input wire logic [15:0] wsVal,
  input wire logic [15:0] extWord,
  // Register result write
  input wire logic regWrStb,
  input wire logic [15:0] regNewVal,
  // Jump and serial bit address
  input wire logic jmpStb,
  input wire logic bitStb,
  input wire logic [7:0] dispVal,
  input wire logic [15:0] pcNext,
  input wire logic [15:0] baseReg,
  // Flag update request
  input wire logic execStb,
  input wire logic [4:0] execOp,
  input wire logic [15:0] srcVal,
  input wire logic [15:0] dstVal,
  input wire logic [15:0] resIn,
  input wire logic shiftOut,
  input wire logic msbChg,
  input wire logic serialIn,
  input wire logic [3:0] serCount,
  // Address results
  output logic [15:0] effAddrFf,
  output logic [15:0] operandFf,
  output logic opndRdyFf,
  output logic memRdFf,
  output logic extUsedFf,
  output logic wbEnFf,
  output logic [15:0] wbValFf,
  output logic [15:0] regOutFf,
  output logic pcLoadFf,
  output logic [15:0] pcTgtFf,
  output logic [11:0] bitAddrFf,
  // Status word
  output logic [15:0] statusFf,
  output logic [3:0] intMask,
  output logic [15:0] resultFf,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdataFf
);

  // Flag set affected by each operation: lgt agt eq cy ov par xop
  function automatic logic [6:0] affMask(input logic [4:0] op, input logic isByte);
    logic [6:0] m;
    m = 7'h00;
    case (op)
      oas_pkg::OP_ADD, oas_pkg::OP_SUB: m = {5'h1f, isByte, 1'b0};
      oas_pkg::OP_INC, oas_pkg::OP_DEC,
      oas_pkg::OP_NEG, oas_pkg::OP_ABS,
      oas_pkg::OP_SHL: m = 7'h7c;
      oas_pkg::OP_SHR: m = 7'h78;
      oas_pkg::OP_CMP, oas_pkg::OP_LOGIC,
      oas_pkg::OP_MOVE: m = {5'h1c, isByte, 1'b0};
      oas_pkg::OP_CMPI: m = 7'h70;
      oas_pkg::OP_SERIAL: m = 7'h72;
      oas_pkg::OP_COC, oas_pkg::OP_CZC,
      oas_pkg::OP_TB: m = 7'h10;
      oas_pkg::OP_DIV: m = 7'h04;
      oas_pkg::OP_XOP: m = 7'h01;
      default: m = 7'h00;
    endcase
    return m;
  endfunction : affMask

  // ---------------- Operand addressing ----------------
  // register zero selects symbolic
  wire isSym = (modeSel == oas_pkg::MODE_IDX) && (regNum == oas_pkg::REG_NONE);
  wire [15:0] incStep = byteOp ? oas_pkg::STEP_BYTE : oas_pkg::STEP_WORD;
  wire [15:0] idxAddr = extWord + wsVal;
  wire isDirect = immSel || (modeSel == oas_pkg::MODE_REG);
  wire [15:0] eaSel = (modeSel == oas_pkg::MODE_IDX) ? (isSym ? extWord : idxAddr) :
                      (modeSel == oas_pkg::MODE_REG) ? oas_pkg::ZERO16 : wsVal;
  wire [15:0] opSel = immSel ? extWord : wsVal;
  wire isAuto = !immSel && (modeSel == oas_pkg::MODE_AUTO);
  wire usesExt = immSel || (modeSel == oas_pkg::MODE_IDX);
  wire [15:0] regMerge = byteOp ?
    {regNewVal[oas_pkg::BYTE_HI:oas_pkg::BYTE_LO], wsVal[oas_pkg::BYTE_LO-1:0]} : regNewVal;
  wire [15:0] jmpSum = pcNext + {{7{dispVal[7]}}, dispVal, 1'b0};
  wire [11:0] bitSum = baseReg[oas_pkg::BASE_HI:oas_pkg::BASE_LO] + {{4{dispVal[7]}}, dispVal};

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      effAddrFf <= oas_pkg::ZERO16;
      operandFf <= oas_pkg::ZERO16;
      opndRdyFf <= 1'b0;
      memRdFf <= 1'b0;
      extUsedFf <= 1'b0;
      wbEnFf <= 1'b0;
      wbValFf <= oas_pkg::ZERO16;
    end else begin
      opndRdyFf <= addrStb && isDirect;
      memRdFf <= addrStb && !isDirect;
      extUsedFf <= addrStb && usesExt;
      wbEnFf <= addrStb && isAuto;
      if (addrStb) begin
        effAddrFf <= immSel ? oas_pkg::ZERO16 : eaSel;
        operandFf <= isDirect ? opSel : oas_pkg::ZERO16;
        wbValFf <= wsVal + incStep;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      regOutFf <= oas_pkg::ZERO16;
      pcLoadFf <= 1'b0;
      pcTgtFf <= oas_pkg::ZERO16;
      bitAddrFf <= 12'h000;
    end else begin
      pcLoadFf <= jmpStb;
      if (regWrStb) regOutFf <= regMerge;
      if (jmpStb) pcTgtFf <= jmpSum;
      if (bitStb) bitAddrFf <= bitSum;
    end
  end

  // ---------------- Flag computation ----------------
  // byte indicator selects lane
  wire [15:0] laneMask = byteOp ? oas_pkg::BYTE_MASK : oas_pkg::WORD_MASK;
  wire [16:0] oneLsb = byteOp ? oas_pkg::ONE_BYTE : oas_pkg::ONE_WORD;
  wire [15:0] aOp = srcVal & laneMask;
  wire [15:0] bOp = dstVal & laneMask;
  wire [16:0] sumAB = {1'b0, aOp} + {1'b0, bOp};
  wire [16:0] difBA = {1'b0, bOp} + {1'b0, ~aOp & laneMask} + oneLsb;
  wire [16:0] difAB = {1'b0, aOp} + {1'b0, ~bOp & laneMask} + oneLsb;
  wire [16:0] negA = {1'b0, ~aOp & laneMask} + oneLsb;
  wire aMsb = aOp[15];
  wire bMsb = bOp[15];
  wire msbSame = (aMsb == bMsb);
  wire aZero = (aOp == oas_pkg::ZERO16);
  wire aMostNeg = (aOp == oas_pkg::MOST_NEG);
  logic [16:0] resFull;

  always_comb begin
    case (execOp)
      oas_pkg::OP_ADD, oas_pkg::OP_INC: resFull = sumAB;
      oas_pkg::OP_SUB, oas_pkg::OP_CMP,
      oas_pkg::OP_CMPI, oas_pkg::OP_DIV: resFull = difBA;
      oas_pkg::OP_DEC: resFull = difAB;
      oas_pkg::OP_NEG: resFull = negA;
      oas_pkg::OP_ABS: resFull = aMsb ? negA : {1'b0, aOp};
      oas_pkg::OP_SERIAL: resFull = {1'b0, aOp};
      default: resFull = {1'b0, resIn & laneMask};
    endcase
  end
  wire [15:0] resVal = resFull[15:0];
  wire resZero = (resVal == oas_pkg::ZERO16);
  wire isCmp = (execOp == oas_pkg::OP_CMP) || (execOp == oas_pkg::OP_CMPI);
  wire isAbs = (execOp == oas_pkg::OP_ABS);
  wire cmpLgt = (aMsb && !bMsb) || (msbSame && resVal[15]);
  wire cmpAgt = (!aMsb && bMsb) || (msbSame && resVal[15]);
  wire newLgt = isCmp ? cmpLgt : isAbs ? !aZero : !resZero;
  wire newAgt = isCmp ? cmpAgt : isAbs ? (!aMsb && !aZero) : (!resVal[15] && !resZero);
  logic newEq;
  logic newCy;
  logic newOv;
  logic newPar;
  always_comb begin
    case (execOp)
      oas_pkg::OP_CMP, oas_pkg::OP_CMPI: newEq = (aOp == bOp);
      oas_pkg::OP_COC: newEq = ((aOp & ~bOp) == oas_pkg::ZERO16);
      oas_pkg::OP_CZC: newEq = ((aOp & bOp) == oas_pkg::ZERO16);
      oas_pkg::OP_TB: newEq = serialIn;
      oas_pkg::OP_ABS: newEq = aZero;
      default: newEq = resZero;
    endcase
  end
  always_comb begin
    case (execOp)
      oas_pkg::OP_SHL, oas_pkg::OP_SHR: newCy = shiftOut;
      oas_pkg::OP_ABS: newCy = aMsb && resFull[16];
      default: newCy = resFull[16];
    endcase
  end
  always_comb begin
    case (execOp)
      oas_pkg::OP_ADD: newOv = msbSame && (resVal[15] != bMsb);
      oas_pkg::OP_SUB: newOv = !msbSame && (resVal[15] != bMsb);
      oas_pkg::OP_INC: newOv = !aMsb && resVal[15];
      oas_pkg::OP_DEC: newOv = aMsb && !resVal[15];
      oas_pkg::OP_SHL: newOv = msbChg;
      oas_pkg::OP_NEG, oas_pkg::OP_ABS: newOv = aMostNeg;
      oas_pkg::OP_DIV: newOv = (!aMsb && bMsb) || (msbSame && !resVal[15]);
      default: newOv = 1'b0;
    endcase
  end
  wire srcPar = ^srcVal[oas_pkg::BYTE_HI:oas_pkg::BYTE_LO];
  wire serOk = (serCount >= oas_pkg::SER_MIN) && (serCount <= oas_pkg::SER_MAX);
  always_comb begin
    case (execOp)
      oas_pkg::OP_CMP, oas_pkg::OP_MOVE: newPar = srcPar;
      oas_pkg::OP_SERIAL: newPar = serOk && srcPar;
      default: newPar = ^resVal[oas_pkg::BYTE_HI:oas_pkg::BYTE_LO];
    endcase
  end
  wire [6:0] newFlags = {newLgt, newAgt, newEq, newCy, newOv, newPar, 1'b1};
  wire [6:0] aff = affMask(execOp, byteOp);
  wire [6:0] oldFlags = statusFf[oas_pkg::FLAG_HI:oas_pkg::FLAG_LO];
  wire [6:0] mergedFlags = (oldFlags & ~aff) | (newFlags & aff);

  // ---------------- Status word ----------------
  logic [15:0] nxt_statusFf;
  always_comb begin
    nxt_statusFf = statusFf;
    if (execStb) begin
      case (execOp)
        oas_pkg::OP_MASK_IMMEDIATE_LOAD: nxt_statusFf[oas_pkg::MASK_HI:oas_pkg::MASK_LO] =
          dstVal[oas_pkg::MASK_HI:oas_pkg::MASK_LO];
        oas_pkg::OP_CONTEXT_RETURN_OP: nxt_statusFf = dstVal;
        default: nxt_statusFf[oas_pkg::FLAG_HI:oas_pkg::FLAG_LO] = mergedFlags;
      endcase
    end else if (regWr && (regAddr == oas_pkg::ADR_STATUS)) begin
      nxt_statusFf = regWdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      statusFf <= oas_pkg::STATUS_RST;
      resultFf <= oas_pkg::ZERO16;
    end else begin
      statusFf <= nxt_statusFf & oas_pkg::STATUS_USED;
      if (execStb) resultFf <= resVal;
    end
  end
  assign intMask = statusFf[oas_pkg::MASK_HI:oas_pkg::MASK_LO];
  // ---------------- Register port ----------------
  logic [15:0] rdSel;
  always_comb begin
    case (regAddr)
      oas_pkg::ADR_STATUS: rdSel = statusFf;
      oas_pkg::ADR_RESULT: rdSel = resultFf;
      oas_pkg::ADR_EADDR: rdSel = effAddrFf;
      oas_pkg::ADR_BITADR: rdSel = {4'h0, bitAddrFf};
      oas_pkg::ADR_PCTGT: rdSel = pcTgtFf;
      default: rdSel = oas_pkg::ZERO16;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) regRdataFf <= oas_pkg::ZERO16;
    else regRdataFf <= regRd ? rdSel : oas_pkg::ZERO16;
  end
  // ---------------- Checks ----------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence seqRegReq;
    addrStb && !immSel && (modeSel == oas_pkg::MODE_REG);
  endsequence
  sequence seqAutoReq;
    addrStb && !immSel && (modeSel == oas_pkg::MODE_AUTO);
  endsequence
  sequence seqXop;
    execStb && (execOp == oas_pkg::OP_XOP);
  endsequence
  AST_REG_DIRECT: assert property (seqRegReq |=>
    opndRdyFf && !memRdFf && (operandFf == $past(wsVal)))
    else $error("register operand not taken directly");
  AST_IND_ADDR: assert property (
    addrStb && !immSel && (modeSel == oas_pkg::MODE_IND)
    |=> memRdFf && !wbEnFf && (effAddrFf == $past(wsVal)))
    else $error("indirect address wrong");
  AST_AUTO_INC: assert property (seqAutoReq |=>
    wbEnFf && memRdFf && (wbValFf == $past(wsVal) + $past(incStep)))
    else $error("auto increment write back wrong");
  AST_AUTO_STEP: assert property (
    seqAutoReq ##0 byteOp |=> (wbValFf - effAddrFf) == oas_pkg::STEP_BYTE)
    else $error("byte auto increment step wrong");
  AST_SYMBOLIC: assert property (
    addrStb && !immSel && isSym |=> effAddrFf == $past(extWord))
    else $error("symbolic address wrong");
  AST_INDEXED: assert property (
    addrStb && !immSel && !isSym && (modeSel == oas_pkg::MODE_IDX)
    |=> extUsedFf && (effAddrFf == $past(extWord) + $past(wsVal)))
    else $error("indexed address wrong");
  AST_IMMEDIATE: assert property (
    addrStb && immSel |=> opndRdyFf && (operandFf == $past(extWord)))
    else $error("immediate operand wrong");
  AST_JUMP: assert property (
    jmpStb |=> pcLoadFf && (pcTgtFf[0] == $past(pcNext[0])) &&
    (($signed(pcTgtFf - $past(pcNext)) >>> 1) == 16'($signed($past(dispVal))))
    ##1 (!pcLoadFf || $past(jmpStb)))
    else $error("jump target or load pulse wrong");
  AST_UNUSED_ZERO: assert property (
    (statusFf & ~oas_pkg::STATUS_USED) == oas_pkg::ZERO16)
    else $error("unused status bits not zero");
  AST_XOP_HOLD: assert property (seqXop |=>
    statusFf[oas_pkg::FLAG_LO] && $stable(statusFf[oas_pkg::FLAG_HI:oas_pkg::FLAG_LO+1]))
    else $error("extended operation disturbed other flags");
  AST_MASK_LOAD: assert property (
    execStb && (execOp == oas_pkg::OP_MASK_IMMEDIATE_LOAD)
    |=> intMask == $past(dstVal[oas_pkg::MASK_HI:oas_pkg::MASK_LO]))
    else $error("interrupt mask not loaded");
  AST_CMP_EQ: assert property (
    execStb && (execOp == oas_pkg::OP_CMP)
    |=> statusFf[oas_pkg::FLAG_HI-2] == ($past(aOp) == $past(bOp)))
    else $error("compare equal flag wrong");
endmodule : oas_core

// [sim/test_operand_addressing_status_flags.sv]
// Directed testbench for the operand addressing and status flag block
`timescale 1ns/1ps
module test_operand_addressing_status_flags;
  logic core_clk, rst_n, addrStb, immSel, byteOp, regWrStb, jmpStb, bitStb, execStb;
  logic shiftOut, msbChg, serialIn, regWr, regRd, opndRdyFf, memRdFf, extUsedFf, wbEnFf;
  logic pcLoadFf;
  logic [1:0] modeSel;
  logic [3:0] regNum, serCount, regAddr, intMask;
  logic [4:0] execOp;
  logic [7:0] dispVal;
  logic [11:0] bitAddrFf;
  logic [15:0] wsVal, extWord, regNewVal, pcNext, baseReg, srcVal, dstVal, resIn, regWdata;
  logic [15:0] effAddrFf, operandFf, wbValFf, regOutFf, pcTgtFf, statusFf, resultFf;
  logic [15:0] regRdataFf, rdv;
  int nMismatch, checked;

  oas_core i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .addrStb(addrStb), .modeSel(modeSel),
    .immSel(immSel), .regNum(regNum), .byteOp(byteOp), .wsVal(wsVal), .extWord(extWord),
    .regWrStb(regWrStb), .regNewVal(regNewVal), .jmpStb(jmpStb), .bitStb(bitStb),
    .dispVal(dispVal), .pcNext(pcNext), .baseReg(baseReg), .execStb(execStb),
    .execOp(execOp), .srcVal(srcVal), .dstVal(dstVal), .resIn(resIn), .shiftOut(shiftOut),
    .msbChg(msbChg), .serialIn(serialIn), .serCount(serCount), .effAddrFf(effAddrFf),
    .operandFf(operandFf), .opndRdyFf(opndRdyFf), .memRdFf(memRdFf),
    .extUsedFf(extUsedFf), .wbEnFf(wbEnFf), .wbValFf(wbValFf), .regOutFf(regOutFf),
    .pcLoadFf(pcLoadFf), .pcTgtFf(pcTgtFf), .bitAddrFf(bitAddrFf), .statusFf(statusFf),
    .intMask(intMask), .resultFf(resultFf), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdataFf(regRdataFf)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, nMismatch);
    if (nMismatch == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      nMismatch++;
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 d = regRdataFf;
  endtask : rd

  // Pulses are packed as {opndRdy, memRd, extUsed, wbEn}
  task automatic ad(input oas_pkg::oas_mode_e m, input logic imm, input logic [3:0] rn,
                    input logic b, input logic [15:0] ws, input logic [15:0] ext,
                    input logic [15:0] eEff, input logic [15:0] eOpd, input logic [3:0] ePul,
                    input logic [15:0] eWb);
    @(posedge core_clk);
    addrStb <= 1'b1;
    modeSel <= m;
    immSel <= imm;
    regNum <= rn;
    byteOp <= b;
    wsVal <= ws;
    extWord <= ext;
    @(posedge core_clk);
    addrStb <= 1'b0;
    #1 chk("effAddr", eEff, effAddrFf);
    chk("operand", eOpd, operandFf);
    chk("pulses", {12'h000, ePul}, {12'h000, opndRdyFf, memRdFf, extUsedFf, wbEnFf});
    if (ePul[0]) chk("wbVal", eWb, wbValFf);
    @(posedge core_clk);
    #1 chk("pulseEnd", 16'h0000, {12'h000, opndRdyFf, memRdFf, extUsedFf, wbEnFf});
  endtask : ad

  task automatic jp(input logic [15:0] pc, input logic [7:0] d, input logic [15:0] e);
    @(posedge core_clk);
    jmpStb <= 1'b1;
    pcNext <= pc;
    dispVal <= d;
    @(posedge core_clk);
    jmpStb <= 1'b0;
    #1 chk("pcTgt", e, pcTgtFf);
    chk("pcLoad", 16'h0001, {15'h0000, pcLoadFf});
    @(posedge core_clk);
    #1 chk("pcLoadEnd", 16'h0000, {15'h0000, pcLoadFf});
  endtask : jp

  task automatic bt(input logic [15:0] base, input logic [7:0] d, input logic [11:0] e);
    @(posedge core_clk);
    bitStb <= 1'b1;
    baseReg <= base;
    dispVal <= d;
    @(posedge core_clk);
    bitStb <= 1'b0;
    #1 chk("bitAddr", {4'h0, e}, {4'h0, bitAddrFf});
  endtask : bt

  task automatic mg(input logic b, input logic [15:0] ws, input logic [15:0] nv,
                    input logic [15:0] e);
    @(posedge core_clk);
    regWrStb <= 1'b1;
    byteOp <= b;
    wsVal <= ws;
    regNewVal <= nv;
    @(posedge core_clk);
    regWrStb <= 1'b0;
    #1 chk("regOut", e, regOutFf);
  endtask : mg

  // Side inputs are packed as {shiftOut, msbChg, serialIn}
  task automatic ex(input oas_pkg::oas_op_e op, input logic b, input logic [15:0] s,
                    input logic [15:0] d, input logic [15:0] r, input logic [2:0] side,
                    input logic [3:0] cnt, input logic [15:0] pre, input logic [15:0] e);
    wr(oas_pkg::ADR_STATUS, pre);
    @(posedge core_clk);
    execStb <= 1'b1;
    execOp <= op;
    byteOp <= b;
    srcVal <= s;
    dstVal <= d;
    resIn <= r;
    {shiftOut, msbChg, serialIn} <= side;
    serCount <= cnt;
    @(posedge core_clk);
    execStb <= 1'b0;
    #1 chk("status", e, statusFf);
  endtask : ex

  initial begin
    repeat (5000) @(posedge core_clk);
    nMismatch++;
    report_and_stop;
  end

  initial begin
    {rst_n, addrStb, immSel, byteOp, regWrStb, jmpStb, bitStb, execStb} = '0;
    {shiftOut, msbChg, serialIn, regWr, regRd, modeSel, regNum, serCount, regAddr} = '0;
    {execOp, dispVal, wsVal, extWord, regNewVal, pcNext, baseReg} = '0;
    {srcVal, dstVal, resIn, regWdata} = '0;
    nMismatch = 0;
    checked = 0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1 chk("statusReset", 16'h0000, statusFf);
    ad(oas_pkg::MODE_REG, 0, 4'h5, 0, 16'h1234, 16'h5555, 16'h0, 16'h1234, 4'b1000, 16'h0);
    ad(oas_pkg::MODE_IND, 0, 4'h5, 0, 16'h2000, 16'h5555, 16'h2000, 16'h0, 4'b0100, 16'h0);
    ad(oas_pkg::MODE_AUTO, 0, 4'h5, 0, 16'h1000, 16'h0, 16'h1000, 16'h0, 4'b0101, 16'h1002);
    ad(oas_pkg::MODE_AUTO, 0, 4'h5, 1, 16'h10ff, 16'h0, 16'h10ff, 16'h0, 4'b0101, 16'h1100);
    ad(oas_pkg::MODE_IDX, 0, 4'h0, 0, 16'h3333, 16'h0400, 16'h0400, 16'h0, 4'b0110, 16'h0);
    ad(oas_pkg::MODE_IDX, 0, 4'h3, 0, 16'h0022, 16'h0400, 16'h0422, 16'h0, 4'b0110, 16'h0);
    ad(oas_pkg::MODE_IND, 1, 4'h5, 0, 16'h1234, 16'hbeef, 16'h0, 16'hbeef, 4'b1010, 16'h0);
    jp(16'h0100, 8'hff, 16'h00fe);
    jp(16'h0100, 8'h7f, 16'h01fe);
    jp(16'h0100, 8'h80, 16'h0000);
    bt(16'h0040, 8'h02, 12'h022);
    bt(16'h0040, 8'hfe, 12'h01e);
    bt(16'h8001, 8'h05, 12'h005);
    mg(1, 16'h1234, 16'habcd, 16'hab34);
    mg(0, 16'h1234, 16'habcd, 16'habcd);
    ex(oas_pkg::OP_ADD, 0, 16'h7fff, 16'h0001, 16'h0, 3'b000, 4'h0, 16'h0, 16'h8800);
    wr(oas_pkg::ADR_RESULT, 16'h1111);
    rd(oas_pkg::ADR_RESULT, rdv);
    chk("resultRead", 16'h8000, rdv);
    rd(4'hf, rdv);
    chk("unmappedRead", 16'h0000, rdv);
    ex(oas_pkg::OP_SUB, 0, 16'h0001, 16'h8000, 16'h0, 3'b000, 4'h0, 16'h0, 16'hd800);
    ex(oas_pkg::OP_CMP, 0, 16'h8000, 16'h0001, 16'h0, 3'b000, 4'h0, 16'h1800, 16'h9800);
    ex(oas_pkg::OP_CMP, 0, 16'h0001, 16'h8000, 16'h0, 3'b000, 4'h0, 16'h0, 16'h4000);
    ex(oas_pkg::OP_CMP, 0, 16'h0002, 16'h0001, 16'h0, 3'b000, 4'h0, 16'h0, 16'hc000);
    ex(oas_pkg::OP_CMP, 0, 16'h1234, 16'h1234, 16'h0, 3'b000, 4'h0, 16'h1800, 16'h3800);
    ex(oas_pkg::OP_CMPI, 0, 16'h0001, 16'h8000, 16'h0, 3'b000, 4'h0, 16'h0, 16'h4000);
    ex(oas_pkg::OP_CMPI, 0, 16'h8000, 16'h0001, 16'h0, 3'b000, 4'h0, 16'h0, 16'h8000);
    ex(oas_pkg::OP_INC, 0, 16'h7fff, 16'h0001, 16'h0, 3'b000, 4'h0, 16'h0, 16'h8800);
    ex(oas_pkg::OP_DEC, 0, 16'h8000, 16'h0001, 16'h0, 3'b000, 4'h0, 16'h0, 16'hd800);
    ex(oas_pkg::OP_NEG, 0, 16'h8000, 16'h0, 16'h0, 3'b000, 4'h0, 16'h0, 16'h8800);
    ex(oas_pkg::OP_ABS, 0, 16'h8000, 16'h0, 16'h0, 3'b000, 4'h0, 16'h0, 16'h8800);
    ex(oas_pkg::OP_ABS, 0, 16'h0000, 16'h0, 16'h0, 3'b000, 4'h0, 16'h1800, 16'h2000);
    ex(oas_pkg::OP_SHL, 0, 16'h0, 16'h0, 16'h0000, 3'b110, 4'h0, 16'h0, 16'h3800);
    ex(oas_pkg::OP_SHR, 0, 16'h0, 16'h0, 16'h4000, 3'b110, 4'h0, 16'h0, 16'hd000);
    ex(oas_pkg::OP_DIV, 0, 16'h0001, 16'h8000, 16'h0, 3'b000, 4'h0, 16'h0, 16'h0800);
    ex(oas_pkg::OP_DIV, 0, 16'h8000, 16'h8000, 16'h0, 3'b000, 4'h0, 16'h0, 16'h0800);
    ex(oas_pkg::OP_DIV, 0, 16'h8000, 16'h0001, 16'h0, 3'b000, 4'h0, 16'h0800, 16'h0);
    ex(oas_pkg::OP_MOVE, 1, 16'h0700, 16'h0, 16'h0700, 3'b000, 4'h0, 16'h1800, 16'hdc00);
    ex(oas_pkg::OP_ADD, 1, 16'h0100, 16'h0100, 16'h0, 3'b000, 4'h0, 16'h0, 16'hc400);
    ex(oas_pkg::OP_SERIAL, 0, 16'h0100, 16'h0, 16'h0, 3'b000, 4'h8, 16'h0, 16'hc400);
    ex(oas_pkg::OP_SERIAL, 0, 16'h0100, 16'h0, 16'h0, 3'b000, 4'h9, 16'h0, 16'hc000);
    ex(oas_pkg::OP_TB, 0, 16'h0, 16'h0, 16'h0, 3'b001, 4'h0, 16'h0, 16'h2000);
    ex(oas_pkg::OP_TB, 0, 16'h0, 16'h0, 16'h0, 3'b000, 4'h0, 16'h2000, 16'h0);
    ex(oas_pkg::OP_CZC, 0, 16'h00f0, 16'h0f00, 16'h0, 3'b000, 4'h0, 16'hd800, 16'hf800);
    ex(oas_pkg::OP_COC, 0, 16'h00f0, 16'h0ff0, 16'h0, 3'b000, 4'h0, 16'h0, 16'h2000);
    ex(oas_pkg::OP_COC, 0, 16'h00f0, 16'h0f00, 16'h0, 3'b000, 4'h0, 16'h2000, 16'h0);
    ex(oas_pkg::OP_CMP, 1, 16'h01ff, 16'h0100, 16'h0, 3'b000, 4'h0, 16'h0, 16'h2400);
    ex(oas_pkg::OP_ADD, 1, 16'h01ff, 16'h00ff, 16'h0, 3'b000, 4'h0, 16'h0, 16'hc400);
    ex(oas_pkg::OP_LOGIC, 0, 16'h0, 16'h0, 16'h0000, 3'b000, 4'h0, 16'h1800, 16'h3800);
    ex(oas_pkg::OP_XOP, 0, 16'h0, 16'h0, 16'h0, 3'b000, 4'h0, 16'h0, 16'h0200);
    ex(oas_pkg::OP_MASK_IMMEDIATE_LOAD, 0, 16'h0, 16'h0005, 16'h0, 3'b000, 4'h0, 16'h8000, 16'h8005);
    chk("intMask", 16'h0005, {12'h000, intMask});
    ex(oas_pkg::OP_CONTEXT_RETURN_OP, 0, 16'h0, 16'hffff, 16'h0, 3'b000, 4'h0, 16'h0, 16'hfe0f);
    wr(oas_pkg::ADR_STATUS, 16'hffff);
    rd(oas_pkg::ADR_STATUS, rdv);
    chk("statusRead", 16'hfe0f, rdv);
    wr(oas_pkg::ADR_STATUS, 16'h0000);
    @(posedge core_clk);
    execStb <= 1'b1;
    execOp <= oas_pkg::OP_XOP;
    regWr <= 1'b1;
    regAddr <= oas_pkg::ADR_STATUS;
    regWdata <= 16'hffff;
    @(posedge core_clk);
    execStb <= 1'b0;
    regWr <= 1'b0;
    #1 chk("execWins", 16'h0200, statusFf);
    report_and_stop;
  end
endmodule : test_operand_addressing_status_flags
